// file: logic/cfs_status_bank.sv
// function status register bank, base registers, info pointer and area loader
// Overview of operation
// [R01] The layout here is only presented while the card select input is high.
// [R02] Base address registers read zero in bits 7-0 and store bits 31-8.
// [R03] Bits 3-0 of all four bank registers always read zero.
// [R04] The event register at 0x0 has general wake-up at bit 4 and interrupt at bit 15.
// [R05] Reserved bits 14-5 and 31-16 of event and reset-status, and bits 13-5 and 31-16 of mask, read zero.
// [R06] The mask register at 0x4 stores bits 4, 14 and 15.
// [R07] Mask bits 13-5 always read zero.
// [R08] The reset-status register at 0x8 stores bits 4 and 15, all others read zero.
// [R09] The force-event register at 0xC takes bits 4 and 15; other bits are unused.
// [R10] The info pointer is read-only and returns 0x00000080.
// [R11] With card select high the info area is filled from a two-wire serial memory.
// [R12] Writes to read-only or unused bits change nothing.
`timescale 1ns/10ps
module cfs_status_bank
	import cfs_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              card_sel_i,
	input  wire logic              cfg_req_i,
	input  wire logic              cfg_wr_i,
	input  wire logic [CFG_AW-1:0] cfg_addr_i,
	input  wire logic [DATA_W-1:0] cfg_wdata_i,
	output logic                   cfg_ack_o,
	output logic      [DATA_W-1:0] cfg_rdata_o,
	input  wire logic              bank_req_i,
	input  wire logic              bank_wr_i,
	input  wire logic [DATA_W-1:0] bank_addr_i,
	input  wire logic [DATA_W-1:0] bank_wdata_i,
	output logic                   bank_ack_o,
	output logic      [DATA_W-1:0] bank_rdata_o,
	input  wire logic              wake_event_i,
	input  wire logic              intr_event_i,
	output logic                   rom_scl_o,
	input  wire logic              rom_sda_i,
	output logic                   rom_sda_o,
	output logic                   rom_sda_oe_o,
	output logic                   cis_loaded_o
);
	localparam int BW = DATA_W - BASE_LSB;

	logic [BW-1:0] base_one_ff, base_two_ff, nxt_base_one, nxt_base_two;
	logic ev_wake_ff, ev_intr_ff, mk_gw_ff, mk_wk_ff, mk_in_ff, rs_gw_ff, rs_in_ff;
	logic nxt_ev_wake, nxt_ev_intr, nxt_mk_gw, nxt_mk_wk, nxt_mk_in, nxt_rs_gw, nxt_rs_in;
	logic bank_hit, bank_wr, cfg_wr;
	logic [7:0] bank_off;
	logic bank_ack_ff, cfg_p1_ff, cfg_ack_ff, cis_rd_ff;
	logic [DATA_W-1:0] bank_rdata_ff, nxt_bank_rdata, p1_rdata_ff, nxt_p1_rdata;
	logic [DATA_W-1:0] cfg_rdata_ff, nxt_cfg_rdata, mem_rdata;
	logic cis_sel;

	// place the three live bit positions of a bank register
	function automatic logic [DATA_W-1:0] fld(input logic b15, input logic b14, input logic b4);
		logic [DATA_W-1:0] v;
		v = '0;
		v[BIT_INTR]      = b15;
		v[BIT_WAKE_MASK] = b14;
		v[BIT_GEN_WAKE]  = b4;
		return v;
	endfunction : fld

	// bank decode against either base
	assign bank_off = bank_addr_i[7:0];
	assign bank_hit = bank_req_i & card_sel_i &                                  // see [R01]
	                  ((bank_addr_i[DATA_W-1:BASE_LSB] == base_one_ff) |
	                   (bank_addr_i[DATA_W-1:BASE_LSB] == base_two_ff));
	assign bank_wr  = bank_hit & bank_wr_i;
	assign cfg_wr   = cfg_req_i & cfg_wr_i & card_sel_i;                         // see [R01]
	assign cis_sel  = cfg_addr_i[CFG_AW-1:CIS_SEL_LSB] == CFG_CARD_INFO_AREA[CFG_AW-1:CIS_SEL_LSB];

	// register next values: software writes, hardware events win over clears
	always_comb begin
		nxt_base_one = base_one_ff;
		nxt_base_two = base_two_ff;
		nxt_ev_wake  = ev_wake_ff;
		nxt_ev_intr  = ev_intr_ff;
		nxt_mk_gw    = mk_gw_ff;
		nxt_mk_wk    = mk_wk_ff;
		nxt_mk_in    = mk_in_ff;
		nxt_rs_gw    = rs_gw_ff;
		nxt_rs_in    = rs_in_ff;
		if (cfg_wr && cfg_addr_i == CFG_BASE_ONE) begin
			nxt_base_one = cfg_wdata_i[DATA_W-1:BASE_LSB];                           // see [R02]
		end
		if (cfg_wr && cfg_addr_i == CFG_BASE_TWO) begin
			nxt_base_two = cfg_wdata_i[DATA_W-1:BASE_LSB];                           // see [R02]
		end
		if (bank_wr && bank_off == OFF_EVENT) begin
			// writing one clears a recorded event
			nxt_ev_wake = ev_wake_ff & ~bank_wdata_i[BIT_GEN_WAKE];                  // see [R04]
			nxt_ev_intr = ev_intr_ff & ~bank_wdata_i[BIT_INTR];
		end
		if (bank_wr && bank_off == OFF_MASK) begin
			nxt_mk_gw = bank_wdata_i[BIT_GEN_WAKE];                                  // see [R06]
			nxt_mk_wk = bank_wdata_i[BIT_WAKE_MASK];
			nxt_mk_in = bank_wdata_i[BIT_INTR];
		end
		if (bank_wr && bank_off == OFF_RSTAT) begin
			nxt_rs_gw = bank_wdata_i[BIT_GEN_WAKE];                                  // see [R08]
			nxt_rs_in = bank_wdata_i[BIT_INTR];
		end
		if (wake_event_i || (bank_wr && bank_off == OFF_FORCE && bank_wdata_i[BIT_GEN_WAKE])) begin
			nxt_ev_wake = 1'b1;                                                      // see [R09]
		end
		if (intr_event_i || (bank_wr && bank_off == OFF_FORCE && bank_wdata_i[BIT_INTR])) begin
			nxt_ev_intr = 1'b1;                                                      // see [R09]
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			base_one_ff <= '0;
			base_two_ff <= '0;
			{ev_wake_ff, ev_intr_ff, mk_gw_ff, mk_wk_ff, mk_in_ff, rs_gw_ff, rs_in_ff} <= '0;
		end else begin
			base_one_ff <= nxt_base_one;
			base_two_ff <= nxt_base_two;
			{ev_wake_ff, ev_intr_ff, mk_gw_ff, mk_wk_ff, mk_in_ff, rs_gw_ff, rs_in_ff} <=
				{nxt_ev_wake, nxt_ev_intr, nxt_mk_gw, nxt_mk_wk, nxt_mk_in, nxt_rs_gw, nxt_rs_in};
		end
	end

	// bank read data; unused and reserved bits are never stored
	always_comb begin
		nxt_bank_rdata = '0;                                                         // see [R03]
		case (bank_off)
			OFF_EVENT: nxt_bank_rdata = fld(ev_intr_ff, 1'b0, ev_wake_ff);           // see [R05]
			OFF_MASK:  nxt_bank_rdata = fld(mk_in_ff, mk_wk_ff, mk_gw_ff);           // see [R07]
			OFF_RSTAT: nxt_bank_rdata = fld(rs_in_ff, 1'b0, rs_gw_ff);               // see [R08]
			default:   nxt_bank_rdata = '0;                                          // see [R12]
		endcase
		if (!bank_hit || bank_wr_i) begin
			nxt_bank_rdata = '0;
		end
	end

	// config read path, stage one picks the register
	always_comb begin
		nxt_p1_rdata = '0;
		if (card_sel_i && !cfg_wr_i) begin                                          // see [R01]
			case (cfg_addr_i)
				CFG_BASE_ONE: nxt_p1_rdata = {base_one_ff, 8'h00};                   // see [R02]
				CFG_BASE_TWO: nxt_p1_rdata = {base_two_ff, 8'h00};
				CFG_CIS_PTR:  nxt_p1_rdata = CIS_PTR_VALUE;                          // see [R10]
				default:      nxt_p1_rdata = '0;
			endcase
		end
		nxt_cfg_rdata = cis_rd_ff ? mem_rdata : p1_rdata_ff;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bank_ack_ff   <= 1'b0;
			bank_rdata_ff <= '0;
			cfg_p1_ff     <= 1'b0;
			cis_rd_ff     <= 1'b0;
			p1_rdata_ff   <= '0;
			cfg_ack_ff    <= 1'b0;
			cfg_rdata_ff  <= '0;
		end else begin
			bank_ack_ff   <= bank_hit;
			bank_rdata_ff <= nxt_bank_rdata;
			cfg_p1_ff     <= cfg_req_i;
			cis_rd_ff     <= cfg_req_i & !cfg_wr_i & card_sel_i & cis_sel & cis_loaded_o;
			p1_rdata_ff   <= nxt_p1_rdata;
			cfg_ack_ff    <= cfg_p1_ff;
			cfg_rdata_ff  <= nxt_cfg_rdata;
		end
	end

	assign bank_ack_o   = bank_ack_ff;
	assign bank_rdata_o = bank_rdata_ff;
	assign cfg_ack_o    = cfg_ack_ff;
	assign cfg_rdata_o  = cfg_rdata_ff;

	// two-wire loader for the information area
	cfs_state_e state_ff, nxt_state;
	logic [DIV_W-1:0] div_ff, nxt_div;
	logic [1:0] ph_ff, nxt_ph, step_ff, nxt_step;
	logic [2:0] bit_ff, nxt_bit;
	logic [5:0] byte_ff, nxt_byte;
	logic [7:0] sh_ff, nxt_sh;
	logic [31:0] word_ff, nxt_word;
	logic scl_ff, nxt_scl, sda_oe_ff, nxt_sda_oe, nack_ff, nxt_nack, ld_ff, nxt_ld;
	logic tick, slot_end, sample, mem_we;

	assign tick     = div_ff == DIV_W'(TW_QUARTER_CYC - 1);
	assign slot_end = tick && ph_ff == PH_LAST;
	assign sample   = tick && ph_ff == PH_SAMPLE;

	always_comb begin
		nxt_div    = tick ? '0 : div_ff + 1'b1;
		nxt_ph     = tick ? ph_ff + 1'b1 : ph_ff;
		nxt_state  = state_ff;
		nxt_step   = step_ff;
		nxt_bit    = bit_ff;
		nxt_byte   = byte_ff;
		nxt_sh     = sh_ff;
		nxt_word   = word_ff;
		nxt_nack   = nack_ff;
		nxt_ld     = ld_ff;
		nxt_scl    = 1'b1;
		nxt_sda_oe = 1'b0;
		mem_we     = 1'b0;
		case (state_ff)
			CFS_IDLE: begin
				if (slot_end && card_sel_i) begin                                   // see [R11]
					nxt_state = CFS_START;
				end
			end
			CFS_START: begin
				nxt_scl    = ph_ff != 2'h0;
				nxt_sda_oe = ph_ff >= PH_SAMPLE;
				if (slot_end) begin
					nxt_sh    = {ROM_DEV_ADDR, step_ff[1]};
					nxt_bit   = '0;
					nxt_state = CFS_SEND;
				end
			end
			CFS_SEND: begin
				nxt_scl    = ph_ff >= PH_SAMPLE;
				nxt_sda_oe = ~sh_ff[7];
				if (slot_end) begin
					nxt_sh  = {sh_ff[6:0], 1'b0};
					nxt_bit = bit_ff + 1'b1;
					if (bit_ff == 3'h7) begin
						nxt_state = CFS_SACK;
					end
				end
			end
			CFS_SACK: begin
				nxt_scl = ph_ff >= PH_SAMPLE;
				if (sample) begin
					nxt_nack = rom_sda_i;
				end
				if (slot_end) begin
					if (nack_ff) begin
						nxt_state = CFS_STOP;
					end else if (step_ff == 2'h0) begin
						nxt_sh    = ROM_START;
						nxt_step  = 2'h1;
						nxt_state = CFS_SEND;
					end else if (step_ff == 2'h1) begin
						nxt_step  = 2'h2;
						nxt_state = CFS_START;
					end else begin
						nxt_byte  = '0;
						nxt_state = CFS_READ;
					end
				end
			end
			CFS_READ: begin
				nxt_scl = ph_ff >= PH_SAMPLE;
				if (sample) begin
					nxt_sh = {sh_ff[6:0], rom_sda_i};
				end
				if (slot_end) begin
					nxt_bit = bit_ff + 1'b1;
					if (bit_ff == 3'h7) begin
						nxt_state = CFS_MACK;
					end
				end
			end
			CFS_MACK: begin
				nxt_scl    = ph_ff >= PH_SAMPLE;
				nxt_sda_oe = byte_ff != CIS_LAST_BYTE;  // nack ends the read
				if (slot_end) begin
					nxt_word = {sh_ff, word_ff[31:8]};
					mem_we   = byte_ff[1:0] == 2'h3;                                 // see [R11]
					nxt_byte = byte_ff + 1'b1;
					nxt_state = (byte_ff == CIS_LAST_BYTE) ? CFS_STOP : CFS_READ;
				end
			end
			CFS_STOP: begin
				nxt_scl    = ph_ff >= PH_SAMPLE;  // data goes low while the clock is low
				nxt_sda_oe = ph_ff != PH_LAST;
				if (slot_end) begin
					nxt_ld    = 1'b1;
					nxt_state = CFS_DONE;
				end
			end
			CFS_DONE: nxt_state = CFS_DONE;
			default:  nxt_state = CFS_IDLE;
		endcase
		// data holds through the falling clock, never moves on the same edge
		if (ph_ff == 2'h0) begin
			nxt_sda_oe = sda_oe_ff;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff  <= CFS_IDLE;
			div_ff    <= '0;
			ph_ff     <= '0;
			step_ff   <= '0;
			bit_ff    <= '0;
			byte_ff   <= '0;
			sh_ff     <= '0;
			word_ff   <= '0;
			nack_ff   <= 1'b0;
			ld_ff     <= 1'b0;
			scl_ff    <= 1'b1;
			sda_oe_ff <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			div_ff    <= nxt_div;
			ph_ff     <= nxt_ph;
			step_ff   <= nxt_step;
			bit_ff    <= nxt_bit;
			byte_ff   <= nxt_byte;
			sh_ff     <= nxt_sh;
			word_ff   <= nxt_word;
			nack_ff   <= nxt_nack;
			ld_ff     <= nxt_ld;
			scl_ff    <= nxt_scl;
			sda_oe_ff <= nxt_sda_oe;
		end
	end

	assign rom_scl_o    = scl_ff;
	assign rom_sda_o    = 1'b0;  // open drain, only ever pulls low
	assign rom_sda_oe_o = sda_oe_ff;
	assign cis_loaded_o = ld_ff;

	cfs_cis_mem u_mem (
		.clk_i   (clk_i),
		.we_i    (mem_we),
		.waddr_i (byte_ff[5:2]),
		.wdata_i ({sh_ff, word_ff[31:8]}),
		.raddr_i (cfg_addr_i[CIS_SEL_LSB-1:2]),
		.rdata_o (mem_rdata)
	);

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	chk_base_low_zero: assert property (cfg_req_i && !cfg_wr_i && card_sel_i && // see [R02]
		cfg_addr_i == CFG_BASE_ONE |-> ##2 cfg_ack_o && cfg_rdata_o[7:0] == 8'h00 &&
		cfg_rdata_o[DATA_W-1:BASE_LSB] == $past(base_one_ff, 2))
		else $error("base read wrong");
	chk_base_write: assert property (cfg_wr && cfg_addr_i == CFG_BASE_TWO |=> // see [R02]
		base_two_ff == $past(cfg_wdata_i[DATA_W-1:BASE_LSB]))
		else $error("base write lost");
	chk_cis_pointer: assert property (cfg_req_i && !cfg_wr_i && card_sel_i && // see [R10]
		cfg_addr_i == CFG_CIS_PTR |-> ##2 cfg_rdata_o == CIS_PTR_VALUE)
		else $error("pointer value wrong");
	chk_nocard_zero: assert property (cfg_req_i && !card_sel_i |-> ##2 // see [R01]
		cfg_ack_o && cfg_rdata_o == '0)
		else $error("config visible without select");
	chk_nouse_zero: assert property (bank_ack_o |-> bank_rdata_o[NOUSE_HI:0] == '0) // see [R03]
		else $error("unused bits nonzero");
	chk_reserved_zero: assert property (bank_ack_o |-> // see [R05]
		(bank_rdata_o & ~fld(1'b1, 1'b1, 1'b1)) == '0)
		else $error("reserved bits nonzero");
	chk_event_set: assert property (wake_event_i |=> ev_wake_ff) // see [R04]
		else $error("event not recorded");
	chk_intr_set: assert property (intr_event_i |=> ev_intr_ff) // see [R04]
		else $error("interrupt event not recorded");
	chk_force_event: assert property (bank_wr && bank_off == OFF_FORCE && // see [R09]
		bank_wdata_i[BIT_INTR] |=> ev_intr_ff) else $error("force did not set");
	chk_mask_write: assert property (bank_wr && bank_off == OFF_MASK |=> // see [R06]
		mk_wk_ff == $past(bank_wdata_i[BIT_WAKE_MASK]) &&
		mk_gw_ff == $past(bank_wdata_i[BIT_GEN_WAKE])) else $error("mask write lost");
	chk_rstat_write: assert property (bank_wr && bank_off == OFF_RSTAT |=> // see [R08]
		rs_in_ff == $past(bank_wdata_i[BIT_INTR])) else $error("reset status write lost");
	chk_fill_select: assert property (state_ff == CFS_IDLE && nxt_state != CFS_IDLE |-> // see [R11]
		card_sel_i) else $error("load started without select");
	chk_ptr_readonly: assert property (cfg_wr && cfg_addr_i == CFG_CIS_PTR |=> // see [R12]
		$stable(base_one_ff) && $stable(base_two_ff)) else $error("read-only write took");

	cov_loaded:    cover property (!cis_loaded_o ##1 cis_loaded_o);
	cov_force:     cover property (bank_wr && bank_off == OFF_FORCE);
	cov_cis_read:  cover property (cis_rd_ff);
endmodule : cfs_status_bank

// file: inc/cfs_pkg.sv
// constants, offsets and state encoding for the function status register bank
package cfs_pkg;
	localparam int          DATA_W        = 32;
	localparam int          CFG_AW        = 8;
	localparam int          BASE_LSB      = 8;
	// status bank offsets, relative to either base address
	localparam logic [7:0]  OFF_EVENT     = 8'h00;
	localparam logic [7:0]  OFF_MASK      = 8'h04;
	localparam logic [7:0]  OFF_RSTAT     = 8'h08;
	localparam logic [7:0]  OFF_FORCE     = 8'h0C;
	// configuration offsets
	localparam logic [7:0]  CFG_BASE_ONE  = 8'h14;
	localparam logic [7:0]  CFG_BASE_TWO  = 8'h18;
	localparam logic [7:0]  CFG_CIS_PTR   = 8'h28;
	localparam logic [7:0]  CFG_CARD_INFO_AREA  = 8'h80;
	localparam logic [31:0] CIS_PTR_VALUE = 32'h00000080;
	// field positions
	localparam int          BIT_GEN_WAKE  = 4;
	localparam int          BIT_WAKE_MASK = 14;
	localparam int          BIT_INTR      = 15;
	localparam int          NOUSE_HI      = 3;
	// information area size
	localparam int          CIS_AW        = 4;
	localparam int          CIS_WORDS     = 16;
	localparam int          CIS_SEL_LSB   = CIS_AW + 2;
	localparam logic [5:0]  CIS_LAST_BYTE = 6'h3F;
	// two-wire timing: quarter of a bit slot, least time, rounded up
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          TW_QUARTER_NS = 2500;
	localparam int          TW_QUARTER_CYC = (TW_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          DIV_W         = 8;
	localparam logic [6:0]  ROM_DEV_ADDR  = 7'h50;
	localparam logic [7:0]  ROM_START     = 8'h00;
	localparam logic [1:0]  PH_SAMPLE     = 2'h2;
	localparam logic [1:0]  PH_LAST       = 2'h3;
	// loader states, gray along the usual path except the repeated start from CFS_SACK to CFS_START
	typedef enum logic [3:0] {
		CFS_IDLE  = 4'h0,
		CFS_START = 4'h1,
		CFS_SEND  = 4'h3,
		CFS_SACK  = 4'h2,
		CFS_READ  = 4'h6,
		CFS_MACK  = 4'h7,
		CFS_STOP  = 4'h5,
		CFS_DONE  = 4'h4
	} cfs_state_e;
endpackage : cfs_pkg

// file: logic/cfs_cis_mem.sv
// information area storage, one write port and a registered read port
`timescale 1ns/10ps
module cfs_cis_mem
	import cfs_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              we_i,
	input  wire logic [CIS_AW-1:0] waddr_i,
	input  wire logic [31:0]       wdata_i,
	input  wire logic [CIS_AW-1:0] raddr_i,
	output logic      [31:0]       rdata_o
);
	logic [31:0] mem [CIS_WORDS];
	logic [31:0] rdata_ff;

	// write from the loader, read data out of a register
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_ff <= mem[raddr_i];
	end

	assign rdata_o = rdata_ff;
endmodule : cfs_cis_mem

// file: tb/cfs_rom_model.sv
// behavioural two-wire serial memory answering the info area loader
`timescale 1ns/10ps
module cfs_rom_model #(
	parameter logic [6:0] DEV_ADDR = 7'h50
) (
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       ack_en_i,
	output logic            sda_low_o,
	output logic      [7:0] first_byte_o
);
	logic [7:0] shift;
	logic [7:0] rdbyte;
	logic [7:0] ptr;
	int         bit_cnt;
	logic       active;
	logic       rd;
	logic       addr_ph;
	logic       got_first;
	logic       mack;
	// idle: line released, nothing seen
	initial begin
		sda_low_o    = 1'b0;
		first_byte_o = 8'h00;
		active       = 1'b0;
		rd           = 1'b0;
		got_first    = 1'b0;
		ptr          = 8'h00;
		bit_cnt      = 0;
	end
	// start or repeated start: data falls while clock high
	always @(negedge sda_i) begin
		if (scl_i === 1'b1) begin
			active  = 1'b1;
			addr_ph = 1'b1;
			rd      = 1'b0;
			bit_cnt = 0;
		end
	end
	// stop: data rises while clock high, line let go
	always @(posedge sda_i) begin
		if (scl_i === 1'b1) begin
			active    = 1'b0;
			sda_low_o = 1'b0;
		end
	end
	// bits and the master's acknowledge are taken on the clock rise
	always @(posedge scl_i) begin
		if (active && bit_cnt < 8)
			shift = {shift[6:0], sda_i};
		if (active && bit_cnt == 8)
			mack = !sda_i;
		if (active)
			bit_cnt++;
	end
	// the line only changes while the clock is low
	always @(negedge scl_i) begin
		if (active && bit_cnt == 8) begin
			if (addr_ph && !got_first) begin
				first_byte_o = shift;
				got_first    = 1'b1;
			end
			if (addr_ph) begin
				sda_low_o = ack_en_i && shift[7:1] == DEV_ADDR;
				rd        = shift[0] && sda_low_o;
				addr_ph   = 1'b0;
			end else if (rd) begin
				sda_low_o = 1'b0;
			end else begin
				sda_low_o = ack_en_i;
				ptr       = shift;
			end
		end else if (active && bit_cnt == 9) begin
			bit_cnt = 0;
			rd      = rd && (mack || sda_low_o);
			rdbyte  = ptr ^ 8'h5A;
			ptr     = ptr + 8'h01;
			sda_low_o = rd && !rdbyte[7];
		end else if (active && rd) begin
			sda_low_o = !rdbyte[7 - bit_cnt];
		end
	end
endmodule : cfs_rom_model

// file: tb/testbench.sv
// self-checking bench for the function status register bank
`timescale 1ns/10ps
module testbench;
	import cfs_pkg::*;
	localparam int         LIMIT = 40000;
	localparam bit         CFG   = 1'b0;
	localparam bit         BNK   = 1'b1;
	localparam logic [23:0] B1   = 24'hFFFFFF;
	localparam logic [23:0] B2   = 24'h123456;
	logic        clk_i;
	logic        reset_n_i;
	logic        card_sel_i;
	logic        cfg_req_i;
	logic        cfg_wr_i;
	logic [7:0]  cfg_addr_i;
	logic [31:0] cfg_wdata_i;
	logic        cfg_ack_o;
	logic [31:0] cfg_rdata_o;
	logic        bank_req_i;
	logic        bank_wr_i;
	logic [31:0] bank_addr_i;
	logic [31:0] bank_wdata_i;
	logic        bank_ack_o;
	logic [31:0] bank_rdata_o;
	logic        wake_event_i;
	logic        intr_event_i;
	logic        rom_scl_o;
	logic        rom_sda_o;
	logic        rom_sda_oe_o;
	logic        cis_loaded_o;
	logic        mem_low;
	logic [7:0]  first_byte;
	wire         sda_line;
	int          err_total;
	int          tests_run;
	int          cyc = 0;
	// pulled-up data line, low when either side pulls it
	assign sda_line = (rom_sda_oe_o | mem_low) ? 1'b0 : 1'b1;
	cfs_status_bank u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .card_sel_i(card_sel_i),
		.cfg_req_i(cfg_req_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
		.cfg_wdata_i(cfg_wdata_i), .cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o),
		.bank_req_i(bank_req_i), .bank_wr_i(bank_wr_i), .bank_addr_i(bank_addr_i),
		.bank_wdata_i(bank_wdata_i), .bank_ack_o(bank_ack_o), .bank_rdata_o(bank_rdata_o),
		.wake_event_i(wake_event_i), .intr_event_i(intr_event_i), .rom_scl_o(rom_scl_o),
		.rom_sda_i(sda_line), .rom_sda_o(rom_sda_o), .rom_sda_oe_o(rom_sda_oe_o),
		.cis_loaded_o(cis_loaded_o));
	// memory told to refuse its address so the loader aborts early
	cfs_rom_model u_rom (.scl_i(rom_scl_o), .sda_i(sda_line), .ack_en_i(1'b0),
		.sda_low_o(mem_low), .first_byte_o(first_byte));
	// clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	// hang guard
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			err_total++;
			$display("unexpected at %0t: run too long", $time);
			conclude();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : check
	// one access on either port, waits a bounded time for the answer
	task automatic acc(input bit bank, input logic wr, input logic [31:0] a,
			input logic [31:0] d, output logic [31:0] q, output logic hit);
		int n;
		@(negedge clk_i);
		cfg_wr_i     = wr;
		bank_wr_i    = wr;
		cfg_addr_i   = a[7:0];
		bank_addr_i  = a;
		cfg_wdata_i  = d;
		bank_wdata_i = d;
		cfg_req_i    = !bank;
		bank_req_i   = bank;
		@(negedge clk_i);
		cfg_req_i  = 1'b0;
		bank_req_i = 1'b0;
		hit = 1'b0;
		q   = '0;
		for (n = 0; n < 4; n++) begin
			if (!hit && (bank ? bank_ack_o : cfg_ack_o) === 1'b1) begin
				hit = 1'b1;
				q   = bank ? bank_rdata_o : cfg_rdata_o;
			end
			@(negedge clk_i);
		end
	endtask : acc
	task automatic expect_rd(input bit bank, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        h;
		acc(bank, 1'b0, a, '0, q, h);
		check({31'h0, h}, 32'h1, "read ack");
		check(q, exp, "read data");
	endtask : expect_rd
	task automatic do_wr(input bit bank, input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        h;
		acc(bank, 1'b1, a, d, q, h);
		check({31'h0, h}, 32'h1, "write ack");
	endtask : do_wr
	task automatic t_card_off();
		logic [31:0] q;
		logic        h;
		card_sel_i = 1'b0;
		expect_rd(CFG, {24'h0, CFG_CIS_PTR}, 32'h0);
		acc(BNK, 1'b0, {24'h0, OFF_EVENT}, '0, q, h);
		check({31'h0, h}, 32'h0, "bank ack while deselected");
		do_wr(CFG, {24'h0, CFG_BASE_ONE}, 32'hFFFFFFFF);
		card_sel_i = 1'b1;
		expect_rd(CFG, {24'h0, CFG_BASE_ONE}, 32'h0);
		$display("test card_off done");
	endtask : t_card_off
	task automatic t_config();
		expect_rd(CFG, {24'h0, CFG_CIS_PTR}, CIS_PTR_VALUE);
		do_wr(CFG, {24'h0, CFG_CIS_PTR}, 32'hFFFFFFFF);
		expect_rd(CFG, {24'h0, CFG_CIS_PTR}, CIS_PTR_VALUE);
		expect_rd(CFG, {24'h0, CFG_BASE_ONE}, 32'h0);
		do_wr(CFG, {24'h0, CFG_BASE_ONE}, 32'hFFFFFFFF);
		expect_rd(CFG, {24'h0, CFG_BASE_ONE}, {B1, 8'h00});
		do_wr(CFG, {24'h0, CFG_BASE_TWO}, {B2, 8'h78});
		expect_rd(CFG, {24'h0, CFG_BASE_TWO}, {B2, 8'h00});
		expect_rd(CFG, {24'h0, CFG_CARD_INFO_AREA}, 32'h0);
		$display("test config done");
	endtask : t_config
	task automatic t_bank_bits();
		do_wr(BNK, {B2, OFF_MASK}, 32'hFFFFFFFF);
		expect_rd(BNK, {B2, OFF_MASK}, 32'h0000C010);
		do_wr(BNK, {B2, OFF_MASK}, 32'h0);
		expect_rd(BNK, {B2, OFF_MASK}, 32'h0);
		do_wr(BNK, {B2, OFF_RSTAT}, 32'hFFFFFFFF);
		expect_rd(BNK, {B2, OFF_RSTAT}, 32'h00008010);
		do_wr(BNK, {B2, OFF_FORCE}, 32'hFFFF7FEF);
		expect_rd(BNK, {B2, OFF_EVENT}, 32'h0);
		do_wr(BNK, {B2, OFF_FORCE}, 32'h00008010);
		expect_rd(BNK, {B2, OFF_FORCE}, 32'h0);
		expect_rd(BNK, {B2, OFF_EVENT}, 32'h00008010);
		do_wr(BNK, {B2, OFF_EVENT}, 32'hFFFFFFFF);
		expect_rd(BNK, {B2, OFF_EVENT}, 32'h0);
		$display("test bank_bits done");
	endtask : t_bank_bits
	task automatic t_hw_events();
		@(negedge clk_i);
		wake_event_i = 1'b1;
		@(negedge clk_i);
		wake_event_i = 1'b0;
		expect_rd(BNK, {B1, OFF_EVENT}, 32'h00000010);
		intr_event_i = 1'b1;
		@(negedge clk_i);
		intr_event_i = 1'b0;
		expect_rd(BNK, {B1, OFF_EVENT}, 32'h00008010);
		do_wr(BNK, {B1, OFF_EVENT}, 32'h00000010);
		expect_rd(BNK, {B1, OFF_EVENT}, 32'h00008000);
		do_wr(BNK, {B1, OFF_EVENT}, 32'h00008000);
		expect_rd(BNK, {B1, OFF_EVENT}, 32'h0);
		$display("test hw_events done");
	endtask : t_hw_events
	task automatic t_decode();
		logic [31:0] q;
		logic        h;
		acc(BNK, 1'b0, {24'h0, OFF_RSTAT}, '0, q, h);
		check({31'h0, h}, 32'h0, "ack on unmapped address");
		expect_rd(BNK, {B1, OFF_RSTAT}, 32'h00008010);
		$display("test decode done");
	endtask : t_decode
	task automatic t_loader();
		int n;
		for (n = 0; n < 30000 && cis_loaded_o !== 1'b1; n++)
			@(negedge clk_i);
		check({31'h0, cis_loaded_o}, 32'h1, "loader finished");
		check({24'h0, first_byte}, 32'h000000A0, "first serial byte");
		check({31'h0, rom_scl_o}, 32'h1, "serial clock idle");
		check({31'h0, rom_sda_oe_o}, 32'h0, "data line released");
		check({31'h0, rom_sda_o}, 32'h0, "data pin only pulls low");
		$display("test loader done");
	endtask : t_loader
	// second reset in mid-run: outputs and registers back to idle
	task automatic t_reset();
		@(negedge clk_i);
		reset_n_i = 1'b0;
		@(negedge clk_i);
		check({31'h0, cis_loaded_o}, 32'h0, "loaded flag in reset");
		check({31'h0, rom_scl_o}, 32'h1, "serial clock in reset");
		check({31'h0, rom_sda_oe_o}, 32'h0, "data line in reset");
		reset_n_i = 1'b1;
		expect_rd(CFG, {24'h0, CFG_BASE_ONE}, 32'h0);
		expect_rd(BNK, {24'h0, OFF_RSTAT}, 32'h0);
		$display("test reset done");
	endtask : t_reset
	// main sequence
	initial begin
		err_total    = 0;
		tests_run    = 0;
		reset_n_i    = 1'b0;
		card_sel_i   = 1'b1;
		cfg_req_i    = 1'b0;
		cfg_wr_i     = 1'b0;
		cfg_addr_i   = 8'h00;
		cfg_wdata_i  = 32'h0;
		bank_req_i   = 1'b0;
		bank_wr_i    = 1'b0;
		bank_addr_i  = 32'h0;
		bank_wdata_i = 32'h0;
		wake_event_i = 1'b0;
		intr_event_i = 1'b0;
		repeat (16) @(negedge clk_i);
		reset_n_i = 1'b1;
		t_card_off();
		t_config();
		t_bank_bits();
		t_hw_events();
		t_decode();
		t_loader();
		t_reset();
		conclude();
	end
endmodule : testbench
